// [common/dif_pkg.sv]
// Constants shared by the interrupt flag front end.
`default_nettype none
package dif_pkg;
    // Flag register layout, one bit per source in priority order
    localparam int IRQ_NUM_EXT  = 4;    // External request pins
    localparam int IRQ_NUM_INT  = 7;    // Serial x2 pairs, two timers, DMA
    localparam int IRQ_WIDTH    = 11;   // Flag register bits (priorities 1..11)
    localparam int IRQ_FLAG_W   = 32;   // Software view of the flag register
    localparam int IRQ_VEC_W    = 4;    // Vector number width
    localparam logic [3:0] IRQ_VEC_NONE = 4'h0;  // Reset vector, also "none"
    localparam logic [3:0] IRQ_VEC_DMA  = 4'hb;  // DMA interrupt vector
    // Reset values
    localparam logic [10:0] FLAG_RESET   = 11'h000;
    localparam logic [10:0] ENABLE_RESET = 11'h000;
    // Pipeline window in which status register traffic sees a cleared enable
    localparam int GIE_WINDOW_CYC = 2;
    localparam logic [1:0] GIE_WINDOW_INIT = 2'h2;
    // Synchroniser depth
    localparam int SYNC_STAGES = 3;
endpackage : dif_pkg
`default_nettype wire

// [rtl/dif_irq_flags.sv]
// Interrupt flag register, synchroniser, gating and acknowledge logic.
`default_nettype none
module dif_irq_flags
    import dif_pkg::*;
#(
    parameter bit EARLY_VARIANT = 1'b0      // Keep the stalled-trap enable quirk
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_i,
    // External request pins, active low, asynchronous
    input  wire logic [IRQ_NUM_EXT-1:0] ext_irq_n_i,
    // Internal one-cycle peripheral pulses, priorities 5..11
    input  wire logic [IRQ_NUM_INT-1:0] int_irq_i,
    // Software access to the flag register
    input  wire logic                  flag_wr_i,
    input  wire logic [IRQ_FLAG_W-1:0] flag_wdata_i,
    output logic      [IRQ_FLAG_W-1:0] flag_rdata_o,
    // Per-source enables for the CPU and DMA processors
    input  wire logic                  enable_wr_i,
    input  wire logic [IRQ_FLAG_W-1:0] enable_wdata_i,
    // CPU status register global enable access
    input  wire logic                  status_wr_i,
    input  wire logic                  status_gie_i,
    output logic                       cpu_global_irq_enable_o,
    // DMA side: synchronisation select and acknowledge
    input  wire logic                  dma_sync_select_i,
    input  wire logic                  dma_ack_i,
    input  wire logic [IRQ_VEC_W-1:0]  dma_ack_vec_i,
    output logic      [IRQ_WIDTH-1:0]  dma_req_o,
    // CPU take and pipeline hints
    input  wire logic                  cpu_take_i,
    input  wire logic                  trap_decode_i,
    input  wire logic                  trap_stall_false_i,
    output logic                       cpu_req_o,
    output logic      [IRQ_VEC_W-1:0]  cpu_vec_o,
    output logic                       gie_window_o,
    // Acknowledge instruction
    input  wire logic                  ack_instr_i,
    input  wire logic [23:0]           ack_addr_i,
    output logic                       irq_ack_pin_n_o,
    output logic                       dummy_rd_o,
    output logic      [23:0]           dummy_addr_o
);

    // Timing overview
    // A low pin is seen by the first synchroniser flop at the next edge,
    // walks through the second and third flops, and sets its flag at the
    // edge after that, so a pin needs four edges to show in the flags.
    // That latency is the price of a safe crossing from the pin domain;
    // a shorter chain would let a metastable level reach the flag logic.
    // Internal pulses are already in the clock domain and set their flag
    // at the very next edge.
    // The read-back, CPU request and DMA request outputs are computed from
    // the next-state values, so they show a change at the same edge that
    // makes it, while still coming straight from output flops.
    // The CPU vector is registered from the current gated flags and so
    // lags the flags by one edge.
    // An acknowledge clears a flag for one cycle only; a pin that is still
    // low sets it again at the following edge. Sources are expected to keep
    // their pulses short, or they are taken more than once.
    // A software write to the flags wins over every event in its cycle;
    // an interrupt that arrives in that cycle is lost, which is the known
    // hazard of polling the flags while sources are active.
    // The DMA enable is not reachable by software: it follows the DMA
    // synchronisation select with one register of delay.
    // The quirk of the early part, where a delayed false conditional trap
    // leaves the global enable cleared, is kept behind a parameter so that
    // software workarounds can be exercised against it.

    // Synchroniser chains, one row per external pin
    logic [SYNC_STAGES-1:0] sync_q [IRQ_NUM_EXT];
    logic [SYNC_STAGES-1:0] next_sync_q [IRQ_NUM_EXT];
    logic [IRQ_WIDTH-1:0]   flag, next_flag;           // Pending flags
    logic [IRQ_WIDTH-1:0]   source_enable_reg;         // Per-source enables
    logic [IRQ_WIDTH-1:0]   next_source_enable_reg;
    logic                   cpu_global_irq_enable, next_gie;             // Status global enable
    logic                   dma_gie, next_dma_gie;     // Hidden DMA enable
    logic [1:0]             win_cnt, next_win_cnt;     // Post-recognition window
    logic [IRQ_NUM_EXT-1:0] ext_req;                   // Synchronised active requests
    logic [IRQ_WIDTH-1:0]   cpu_gated;                 // Flags passed to the CPU
    logic [IRQ_WIDTH-1:0]   take_mask;                 // Highest enabled flag one-hot
    logic [IRQ_VEC_W-1:0]   take_vec;                  // Its vector
    logic [IRQ_WIDTH-1:0]   dma_clr;                   // DMA acknowledge decode
    logic                   take;                      // CPU recognises now
    logic                   trap_block;                // Trap decode blocks
    logic                   ack_pin_n, next_ack_pin_n;
    logic                   dummy_rd, next_dummy_rd;
    logic [23:0]            dummy_addr, next_dummy_addr;

    // Sampling and synchronising each pin; the third flop is the latch point
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_NUM_EXT; gi++) begin : g_sync
            always_comb begin
                next_sync_q[gi] = {sync_q[gi][SYNC_STAGES-2:0], ~ext_irq_n_i[gi]};
            end
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    sync_q[gi] <= '0;
                end else begin
                    sync_q[gi] <= next_sync_q[gi];
                end
            end
            // Only the last stage is read, the first two just settle
            assign ext_req[gi] = sync_q[gi][SYNC_STAGES-1];
        end
    endgenerate

    // Trap decode holds interrupts off so the trap wins; this blocks only
    // the CPU take, the DMA side keeps seeing its requests meanwhile
    assign trap_block = trap_decode_i;

    // CPU view of flags: flag AND source enable AND global enable
    assign cpu_gated = flag & source_enable_reg & {IRQ_WIDTH{cpu_global_irq_enable & ~trap_block}};

    // Lowest index is highest priority; bit k maps to vector k+1
    // The loop runs from the lowest priority up so that the last match,
    // the highest priority, is the one that stays in the mask
    // Vector zero belongs to reset and doubles as the no-request value
    always_comb begin
        take_mask = '0;
        take_vec  = IRQ_VEC_NONE;
        for (int k = IRQ_WIDTH - 1; k >= 0; k--) begin
            if (cpu_gated[k]) begin
                take_mask = '0;
                take_mask[k] = 1'b1;
                take_vec  = IRQ_VEC_W'(k + 1);
            end
        end
    end

    assign take = cpu_take_i & (|cpu_gated);

    // DMA acknowledge decode of the vector into a flag bit
    always_comb begin
        dma_clr = '0;
        if (dma_ack_i && dma_ack_vec_i != IRQ_VEC_NONE && dma_ack_vec_i <= IRQ_VEC_DMA) begin
            dma_clr[dma_ack_vec_i - 4'h1] = 1'b1;
        end
    end

    // Flag next state: sources set, acks clear, a CPU write overrides all
    always_comb begin
        next_flag = flag;
        // Acknowledge clears; a still-low pin sets it back next cycle
        next_flag = next_flag & ~(take ? take_mask : '0) & ~dma_clr;
        next_flag[IRQ_NUM_EXT-1:0] = next_flag[IRQ_NUM_EXT-1:0]
                                   | (ext_req & ~(take ? take_mask[IRQ_NUM_EXT-1:0] : '0)
                                      & ~dma_clr[IRQ_NUM_EXT-1:0]);
        // Internal pulses are one cycle long, taken as they come
        next_flag[IRQ_WIDTH-1:IRQ_NUM_EXT] = next_flag[IRQ_WIDTH-1:IRQ_NUM_EXT] | int_irq_i;
        if (flag_wr_i) begin
            // Write wins over a simultaneous event, which is then lost
            next_flag = flag_wdata_i[IRQ_WIDTH-1:0];
        end
    end

    // Enables and the CPU global enable
    always_comb begin
        next_source_enable_reg = source_enable_reg;
        next_gie               = cpu_global_irq_enable;
        next_win_cnt           = (win_cnt != 2'h0) ? win_cnt - 2'h1 : 2'h0;
        if (enable_wr_i) begin
            next_source_enable_reg = enable_wdata_i[IRQ_WIDTH-1:0];
        end
        // A stalled false trap on the early part leaves the enable low
        if (EARLY_VARIANT && trap_stall_false_i) begin
            next_gie = 1'b0;
        end
        if (take) begin
            next_gie     = 1'b0;
            next_win_cnt = GIE_WINDOW_INIT;
        end
        // A status load in the window can still set it back
        if (status_wr_i) begin
            next_gie = status_gie_i;
        end
    end

    // Hidden DMA enable follows the synchronisation select only
    always_comb begin
        next_dma_gie = dma_sync_select_i;
    end

    // Acknowledge instruction: pin low and dummy read for one cycle
    always_comb begin
        next_ack_pin_n  = ~ack_instr_i;
        next_dummy_rd   = ack_instr_i;
        next_dummy_addr = ack_instr_i ? ack_addr_i : dummy_addr;
    end

    // State registers; reset clears flags, enables and status
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag              <= FLAG_RESET;
            source_enable_reg <= ENABLE_RESET;
            cpu_global_irq_enable               <= 1'b0;
            dma_gie           <= 1'b0;
            win_cnt           <= 2'h0;
            ack_pin_n         <= 1'b1;
            dummy_rd          <= 1'b0;
            dummy_addr        <= 24'h000000;
        end else begin
            flag              <= next_flag;
            source_enable_reg <= next_source_enable_reg;
            cpu_global_irq_enable               <= next_gie;
            dma_gie           <= next_dma_gie;
            win_cnt           <= next_win_cnt;
            ack_pin_n         <= next_ack_pin_n;
            dummy_rd          <= next_dummy_rd;
            dummy_addr        <= next_dummy_addr;
        end
    end

    // Registered outputs
    logic [IRQ_FLAG_W-1:0] rdata_q;
    logic                  cpu_req_q;
    logic [IRQ_VEC_W-1:0]  cpu_vec_q;
    logic [IRQ_WIDTH-1:0]  dma_req_q;

    // Output flops so the read-back, request and vector ports come straight from a register
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q   <= '0;
            cpu_req_q <= 1'b0;
            cpu_vec_q <= IRQ_VEC_NONE;
            dma_req_q <= '0;
        end else begin
            rdata_q   <= {{(IRQ_FLAG_W-IRQ_WIDTH){1'b0}}, next_flag};
            cpu_req_q <= |(next_flag & next_source_enable_reg) & next_gie;
            cpu_vec_q <= take_vec;
            dma_req_q <= next_flag & next_source_enable_reg & {IRQ_WIDTH{next_dma_gie}};
        end
    end

    assign flag_rdata_o            = rdata_q;
    assign cpu_req_o               = cpu_req_q;
    assign cpu_vec_o               = cpu_vec_q;
    assign dma_req_o               = dma_req_q;
    assign cpu_global_irq_enable_o = cpu_global_irq_enable;
    assign gie_window_o            = (win_cnt != 2'h0);
    assign irq_ack_pin_n_o         = ack_pin_n;
    assign dummy_rd_o              = dummy_rd;
    assign dummy_addr_o            = dummy_addr;

endmodule : dif_irq_flags
`default_nettype wire

// [verification/dif_irq_flags_sva.sv]
// Concurrent checks on the ports of the interrupt flag front end.
`default_nettype none
module dif_irq_flags_sva (
    // Clock, reset and one-bit requests
    input wire logic        ref_clk_i, reset_i, flag_wr_i, status_wr_i, status_gie_i,
    input wire logic        cpu_take_i, trap_decode_i, ack_instr_i,
    // One-bit design outputs
    input wire logic        cpu_global_irq_enable_o, cpu_req_o, gie_window_o,
    input wire logic        irq_ack_pin_n_o, dummy_rd_o,
    // Wide values
    input wire logic [31:0] flag_wdata_i, flag_rdata_o,
    input wire logic [10:0] dma_req_o,
    input wire logic [23:0] ack_addr_i, dummy_addr_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // A take the design must honour; a same-cycle status write wins instead
    logic took;
    assign took = cpu_take_i && cpu_req_o && !trap_decode_i && !status_wr_i;

    a_take_clears_gie: assert property (took |=> !cpu_global_irq_enable_o)
        else $error("global enable still set after take");
    a_gie_window_two: assert property (took |=> gie_window_o [*2])
        else $error("status window not held two cycles");
    a_trap_holds_gie: assert property (trap_decode_i && cpu_global_irq_enable_o
        && !status_wr_i |=> cpu_global_irq_enable_o)
        else $error("take accepted during trap decode");
    a_status_load: assert property (status_wr_i |=>
        cpu_global_irq_enable_o == $past(status_gie_i))
        else $error("status write not loaded");
    a_gie_gates_cpu: assert property (!cpu_global_irq_enable_o |-> !cpu_req_o)
        else $error("cpu request with enable clear");
    a_dma_needs_flag: assert property ((dma_req_o & ~flag_rdata_o[10:0]) == 11'h000)
        else $error("dma request without flag");
    a_flag_write_wins: assert property (flag_wr_i |=>
        flag_rdata_o[10:0] == $past(flag_wdata_i[10:0]))
        else $error("flag write not taken");
    a_unused_zero: assert property (flag_rdata_o[31:11] == 21'h000000)
        else $error("unused flag bits set");
    a_ack_pulse: assert property (ack_instr_i |=> !irq_ack_pin_n_o && dummy_rd_o
        && dummy_addr_o == $past(ack_addr_i))
        else $error("ack pin or dummy read missing");
    a_ack_idle: assert property (!ack_instr_i |=> irq_ack_pin_n_o && !dummy_rd_o)
        else $error("ack pin without instruction");

    // Main scenarios
    c_take: cover property (took);
    c_ack_twice: cover property (ack_instr_i ##1 ack_instr_i);
    c_write_pending: cover property (flag_wr_i && cpu_req_o);
endmodule : dif_irq_flags_sva

bind dif_irq_flags dif_irq_flags_sva u_sva (.*);
`default_nettype wire

// [verification/dif_ext_src.sv]
// Model of the external sources that pull the request pins low.
`default_nettype none
module dif_ext_src (
    // Clock and commands from the bench
    input wire logic       ref_clk_i,
    input wire logic [3:0] go_i,
    input wire logic       long_i,
    // Active-low request pins
    output logic     [3:0] ext_irq_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [4];  // Low cycles left per pin
    initial ext_irq_n_o = 4'hf;
    // Short pulses last one or two cycles; long ones outlast an acknowledge
    always @(posedge ref_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (cnt[i] > 0) cnt[i]--;
            else if (go_i[i]) cnt[i] = long_i ? 6 : 1 + i % 2;
        end
    end
    // Pins move on the falling edge only and idle high
    always @(negedge ref_clk_i) begin
        for (int i = 0; i < 4; i++) ext_irq_n_o[i] <= (cnt[i] == 0);
    end
endmodule : dif_ext_src
`default_nettype wire

// [verification/dif_irq_flags_tb.sv]
// Self-checking bench for the interrupt flag front end.
`default_nettype none
module dif_irq_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        flag_wr_i, enable_wr_i, status_wr_i, status_gie_i, dma_sync_select_i;
    logic        dma_ack_i, cpu_take_i, trap_decode_i, trap_stall_false_i, ack_instr_i;
    logic        cpu_global_irq_enable_o, cpu_req_o, gie_window_o, irq_ack_pin_n_o;
    logic        dummy_rd_o, long_i, mg, msel, mack;  // Model ack pulse
    logic [31:0] flag_wdata_i, enable_wdata_i, flag_rdata_o;
    logic [3:0]  dma_ack_vec_i, go_i, ext_irq_n_i, cpu_vec_o, s0, s1, s2, mvec;
    logic [6:0]  int_irq_i;
    logic [10:0] dma_req_o, mf, men;  // Model flags and enables
    logic [23:0] ack_addr_i, dummy_addr_o, mad;  // Model dummy read address
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          mwin = 0;                       // Model status window count

    initial forever #4 ref_clk_i = ~ref_clk_i;
    dif_irq_flags dut (.*);
    dif_ext_src u_src (.ref_clk_i, .go_i, .long_i, .ext_irq_n_o(ext_irq_n_i));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic idle();
        {flag_wr_i, enable_wr_i, status_wr_i, status_gie_i, dma_sync_select_i, dma_ack_i,
         cpu_take_i, trap_decode_i, trap_stall_false_i, ack_instr_i, long_i} = '0;
        {go_i, int_irq_i, dma_ack_vec_i, flag_wdata_i, enable_wdata_i, ack_addr_i} = '0;
    endtask : idle

    // Synchroniser model resets to the idle (high) level
    task automatic model_reset();
        {mf, men, mg, msel, s0, s1, s2} = {24'h000000, 12'hfff};
        {mvec, mack, mad} = '0;
        mwin = 0;
    endtask : model_reset

    // One clock edge of the reference model, fed with the held inputs
    task automatic step();
        logic [10:0] clr;
        logic [10:0] nf;
        int          pick;
        clr = '0;
        pick = -1;
        if (dma_ack_i && dma_ack_vec_i inside {[1:11]}) clr[dma_ack_vec_i - 1] = 1'b1;
        for (int k = 10; k >= 0; k--) if (mf[k] && men[k]) pick = k;
        if (trap_decode_i || !mg) pick = -1;
        mvec = 4'(pick + 1);
        if (!cpu_take_i) pick = -1;
        if (pick >= 0) clr[pick] = 1'b1;
        if (pick >= 0) mwin = 2;
        else if (mwin > 0) mwin--;
        mack = ack_instr_i;
        if (ack_instr_i) mad = ack_addr_i;
        // Internal pulses set after the clear, so a same-cycle ack loses to them
        nf = ((mf | {7'h00, ~s2}) & ~clr) | {int_irq_i, 4'h0};
        if (flag_wr_i) nf = flag_wdata_i[10:0];
        if (status_wr_i) mg = status_gie_i;
        else if (pick >= 0) mg = 1'b0;
        if (enable_wr_i) men = enable_wdata_i[10:0];
        {mf, msel, s2, s1, s0} = {nf, dma_sync_select_i, s1, s0, ext_irq_n_i};
    endtask : step

    task automatic compare();
        check(flag_rdata_o, {21'h000000, mf});
        check(32'(cpu_global_irq_enable_o), 32'(mg));
        check(32'(dma_req_o), 32'(mf & men & {11{msel}}));
        if (!trap_decode_i) check(32'(cpu_req_o), 32'(|(mf & men) & mg));
        check(32'(cpu_vec_o), 32'(mvec));
        check(32'(gie_window_o), 32'(mwin != 0));
        check(32'(irq_ack_pin_n_o), 32'(!mack));
        check(32'(dummy_rd_o), 32'(mack));
        check(32'(dummy_addr_o), 32'(mad));
    endtask : compare

    // Random traffic; takes only while the enable is set
    task automatic drive();
        logic [31:0] r;
        r = $urandom;
        flag_wr_i = (r[3:0] == 4'h0);
        flag_wdata_i = $urandom;
        enable_wr_i = (r[6:4] == 3'h0);
        enable_wdata_i = $urandom;
        status_wr_i = (r[10:7] == 4'h0);
        status_gie_i = r[11];
        dma_sync_select_i = r[12];
        int_irq_i = (r[14:13] == 2'h0) ? 7'(1 << $urandom_range(6)) : 7'h00;
        dma_ack_i = (r[17:15] == 3'h0);
        dma_ack_vec_i = 4'($urandom_range(11, 1));
        cpu_take_i = (r[20:18] == 3'h0) && mg;
        trap_decode_i = (r[23:21] == 3'h0);
        trap_stall_false_i = r[24] && trap_decode_i;
        go_i = (r[27:25] == 3'h0) ? 4'($urandom) : 4'h0;
        long_i = r[28];
        ack_instr_i = (r[30:29] == 2'h0);
        ack_addr_i = 24'($urandom);
    endtask : drive

    task automatic run(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            step();
            @(negedge ref_clk_i);
            compare();
            drive();
        end
    endtask : run

    initial begin
        idle();
        model_reset();
        void'($urandom(63163));
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        run(3000);
        // Reset in mid-run must clear state at once
        @(negedge ref_clk_i);
        idle();
        reset_i = 1'b1;
        #1;
        model_reset();
        compare();
        check(32'(irq_ack_pin_n_o), 32'h1);
        repeat (10) @(negedge ref_clk_i);
        reset_i = 1'b0;
        run(2000);
        print_verdict();
    end

    // Watchdog sized well beyond the 5000-cycle run
    initial begin
        #60000;
        error_cnt++;
        print_verdict();
    end
endmodule : dif_irq_flags_tb
`default_nettype wire
